// ===== spi_cs_pkg.sv
// Shared constants and types for the clock-stop serial port
package spi_cs_pkg;
    localparam int          AXI_ADDR_W   = 8;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_TXDATA  = 8'h04;
    localparam logic [7:0]  ADDR_RXDATA  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
    localparam int          CTRL_MODE    = 0;
    localparam int          CTRL_SRC     = 2;
    localparam int          CTRL_TXPOL   = 3;
    localparam int          CTRL_RXPOL   = 4;
    localparam int          CTRL_TXCDIR  = 5;
    localparam int          CTRL_RXCDIR  = 6;
    localparam int          CTRL_TXFDIR  = 7;
    localparam int          CTRL_RXFDIR  = 8;
    localparam int          CTRL_DIV     = 16;
    localparam int          DIV_BITS     = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h0001_001e;
    localparam logic [31:0] CTRL_MASK    = 32'h00ff_01ff;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_RXFULL  = 1;
    localparam int          STAT_PEND    = 2;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    localparam int          CPU_PER_RATE = 4;
    localparam logic [1:0]  RATE_LAST    = 2'(CPU_PER_RATE - 1);
    localparam int          PHASE_W      = 9;
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_LAG, ST_SLAVE} xfer_state_t;
endpackage

// ===== rate_tick_gen.sv
// Rate-generator input tick: quarter CPU clock or external rate clock edge
`timescale 1ns/100ps
`default_nettype none
module rate_tick_gen (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic src_sel,
    input  wire logic rate_clock_in,
    output logic      tick
);
    import spi_cs_pkg::*;

    typedef struct packed {
        logic [1:0] div;
        logic       prev;
        logic       tick;
    } rate_state_t;

    rate_state_t s_reg;
    rate_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.div  = 2'(s_reg.div + 2'h1);
        s_next.prev = rate_clock_in;
        s_next.tick = src_sel ? (s_reg.div == RATE_LAST) : (rate_clock_in & ~s_reg.prev);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    a_quarter_rate: assert property (@(posedge clk) disable iff (!arst_n)
        src_sel[*5] ##0 $past(tick, 4) |-> tick && !$past(tick, 1))
        else $error("rate tick not every fourth cpu clock");
endmodule
`default_nettype wire

// ===== link_pin_edges.sv
// Edge and slave-enable decode of the link pins seen in slave role
`timescale 1ns/100ps
`default_nettype none
module link_pin_edges (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic bit_clock_in,
    input  wire logic tx_fs_in,
    input  wire logic rx_fs_in,
    input  wire logic tx_pol,
    input  wire logic rx_pol,
    output logic      rise,
    output logic      fall,
    output logic      tx_sel,
    output logic      rx_sel
);
    import spi_cs_pkg::*;

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
        logic tx_sel;
        logic rx_sel;
    } edge_state_t;

    edge_state_t s_reg;
    edge_state_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.prev   = bit_clock_in;
        s_next.rise   = bit_clock_in & ~s_reg.prev;
        s_next.fall   = ~bit_clock_in & s_reg.prev;
        s_next.tx_sel = tx_pol ? ~tx_fs_in : tx_fs_in;
        s_next.rx_sel = rx_pol ? ~rx_fs_in : rx_fs_in;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '{prev: 1'b1, default: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rise   = s_reg.rise;
    assign fall   = s_reg.fall;
    assign tx_sel = s_reg.tx_sel;
    assign rx_sel = s_reg.rx_sel;

    a_enable_inverted: assert property (@(posedge clk) disable iff (!arst_n)
        $past(tx_pol) && $past(rx_pol) |-> tx_sel == !$past(tx_fs_in) && rx_sel == !$past(rx_fs_in))
        else $error("active-low slave enable not inverted");
endmodule
`default_nettype wire

// ===== spi_clock_stop_port.sv
// Clock-stop serial port, master and slave role, with AXI4-Lite registers
// What this block does
// - Rate input is four CPU clocks or external
// - Master bit period is divider plus one, two at divider zero
// - High phase length follows divider parity
// - Low phase length follows divider parity
// - Master drives frame sync as active low
// - Slave inverts both active-low frame inputs
// - Enable falls before first rising clock edge
// - Lead: high phase or full period
// - Lag: full period or high phase
// - Mode 10b launches data on falling edge
// - Mode 11b launches data on rising edge
// - Input data sampled on rising edge
// - Master releases data at last rising edge in 11b, a high phase after it in 10b
// - Slave releases data when enable returns high
// - First bit valid after enable falls
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module spi_clock_stop_port #(
    parameter int WORD_BITS = 8
) (
    input  wire logic                               clk,
    input  wire logic                               arst_n,
    input  wire logic [spi_cs_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [spi_cs_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    input  wire logic                               rate_clock_in,
    input  wire logic                               serial_bit_clock_in,
    output logic                                    serial_bit_clock_out,
    output logic                                    serial_bit_clock_oe,
    input  wire logic                               tx_frame_sync_in,
    output logic                                    tx_frame_sync_out,
    output logic                                    tx_frame_sync_oe,
    input  wire logic                               rx_frame_sync_in,
    input  wire logic                               serial_data_in,
    output logic                                    serial_data_out,
    output logic                                    serial_data_out_oe
);
    import spi_cs_pkg::*;

    localparam int CW = $clog2(WORD_BITS + 1);

    if (WORD_BITS < 2 || WORD_BITS > 32) begin : g_check
        $error("WORD_BITS must lie between 2 and 32");
    end

    typedef struct packed {
        logic [31:0]          ctrl;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic [WORD_BITS-1:0] tx_word;
        logic [WORD_BITS-1:0] tx_sh;
        logic [WORD_BITS-1:0] rx_sh;
        logic [WORD_BITS-1:0] rx_word;
        logic                 pend;
        logic                 rx_full;
        logic [CW-1:0]        nbit;
        xfer_state_t          st;
        logic [PHASE_W-1:0]   cnt;
        logic                 clk_o;
        logic                 fs_o;
        logic                 dout;
        logic                 dout_oe;
    } state_t;

    state_t             s_reg;
    state_t             s_next;
    logic               tick;
    logic               sl_rise;
    logic               sl_fall;
    logic               tx_sel;
    logic               rx_sel;
    logic               master;
    logic               cstop;
    logic               mode11;
    logic [PHASE_W-1:0] len_h;
    logic [PHASE_W-1:0] len_l;
    logic [PHASE_W-1:0] len_t;

    function automatic logic [PHASE_W-1:0] high_len(input logic [DIV_BITS-1:0] d);
        if (d == '0) return 9'h001;
        else if (!d[0]) return 9'({2'b00, d[7:1]} + 9'h001);
        else return 9'(({1'b0, d} + 9'h001) >> 1);
    endfunction

    function automatic logic [PHASE_W-1:0] low_len(input logic [DIV_BITS-1:0] d);
        if (d == '0) return 9'h001;
        else if (!d[0]) return {2'b00, d[7:1]};
        else return 9'(({1'b0, d} + 9'h001) >> 1);
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a[7:4] == 4'h0;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                          input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) r[8*i +: 8] = w[8*i +: 8];
        end
        return r;
    endfunction

    rate_tick_gen u_rate (
        .clk           (clk),
        .arst_n        (arst_n),
        .src_sel       (s_reg.ctrl[CTRL_SRC]),
        .rate_clock_in (rate_clock_in),
        .tick          (tick)
    );

    link_pin_edges u_edges (
        .clk          (clk),
        .arst_n       (arst_n),
        .bit_clock_in (serial_bit_clock_in),
        .tx_fs_in     (tx_frame_sync_in),
        .rx_fs_in     (rx_frame_sync_in),
        .tx_pol       (s_reg.ctrl[CTRL_TXPOL]),
        .rx_pol       (s_reg.ctrl[CTRL_RXPOL]),
        .rise         (sl_rise),
        .fall         (sl_fall),
        .tx_sel       (tx_sel),
        .rx_sel       (rx_sel)
    );

    assign master = s_reg.ctrl[CTRL_TXCDIR];
    assign cstop  = s_reg.ctrl[CTRL_MODE+1];
    assign mode11 = s_reg.ctrl[CTRL_MODE];
    assign len_h  = high_len(s_reg.ctrl[CTRL_DIV +: DIV_BITS]);
    assign len_l  = low_len(s_reg.ctrl[CTRL_DIV +: DIV_BITS]);
    assign len_t  = 9'(len_h + len_l);

    always_comb begin
        logic [PHASE_W-1:0] c1;
        logic [31:0]        wv;
        c1     = 9'(s_reg.cnt + 9'h001);
        wv     = '0;
        s_next = s_reg;
        // Read channel, before transfer logic so a completing word re-sets full
        if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
                ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
                ADDR_RXDATA: begin
                    s_next.rdata   = 32'(s_reg.rx_word);
                    s_next.rx_full = 1'b0;
                end
                ADDR_STATUS: s_next.rdata = {29'h0, s_reg.pend, s_reg.rx_full,
                                             s_reg.st != ST_IDLE};
                default:     s_next.rdata = '0;
            endcase
        end
        case (s_reg.st)
            ST_IDLE: begin
                if (cstop && master && s_reg.pend && tick) begin
                    s_next.pend  = 1'b0;
                    s_next.tx_sh = s_reg.tx_word;
                    s_next.nbit  = '0;
                    s_next.cnt   = '0;
                    s_next.fs_o  = ~s_reg.ctrl[CTRL_TXPOL];
                    s_next.st    = ST_LEAD;
                end else if (cstop && !master && tx_sel) begin
                    s_next.pend    = 1'b0;
                    s_next.dout    = s_reg.tx_word[WORD_BITS-1];
                    s_next.tx_sh   = s_reg.tx_word << 1;
                    s_next.dout_oe = 1'b1;
                    s_next.nbit    = '0;
                    s_next.st      = ST_SLAVE;
                end
            end
            ST_LEAD: begin
                if (tick) begin
                    s_next.cnt = c1;
                    if (mode11 && c1 == len_l) begin
                        s_next.dout    = s_reg.tx_sh[WORD_BITS-1];
                        s_next.tx_sh   = s_reg.tx_sh << 1;
                        s_next.dout_oe = 1'b1;
                    end
                    if (c1 == (mode11 ? len_t : len_h)) begin
                        s_next.clk_o = 1'b0;
                        s_next.cnt   = '0;
                        s_next.st    = ST_LOW;
                        if (!mode11) begin
                            s_next.dout    = s_reg.tx_sh[WORD_BITS-1];
                            s_next.tx_sh   = s_reg.tx_sh << 1;
                            s_next.dout_oe = 1'b1;
                        end
                    end
                end
            end
            ST_LOW: begin
                if (tick) begin
                    s_next.cnt = c1;
                    if (c1 == len_l) begin
                        s_next.clk_o = 1'b1;
                        s_next.cnt   = '0;
                        s_next.rx_sh = {s_reg.rx_sh[WORD_BITS-2:0], serial_data_in};
                        s_next.nbit  = CW'(s_reg.nbit + 1'b1);
                        if (s_reg.nbit == CW'(WORD_BITS - 1)) begin
                            s_next.st = ST_LAG;
                            if (mode11) s_next.dout_oe = 1'b0;
                        end else begin
                            s_next.st = ST_HIGH;
                            if (mode11) begin
                                s_next.dout  = s_reg.tx_sh[WORD_BITS-1];
                                s_next.tx_sh = s_reg.tx_sh << 1;
                            end
                        end
                    end
                end
            end
            ST_HIGH: begin
                if (tick) begin
                    s_next.cnt = c1;
                    if (c1 == len_h) begin
                        s_next.clk_o = 1'b0;
                        s_next.cnt   = '0;
                        s_next.st    = ST_LOW;
                        if (!mode11) begin
                            s_next.dout  = s_reg.tx_sh[WORD_BITS-1];
                            s_next.tx_sh = s_reg.tx_sh << 1;
                        end
                    end
                end
            end
            ST_LAG: begin
                if (tick) begin
                    s_next.cnt = c1;
                    if (!mode11 && c1 == len_h) s_next.dout_oe = 1'b0;
                    if (c1 == (mode11 ? len_h : len_t)) begin
                        s_next.fs_o    = s_reg.ctrl[CTRL_TXPOL];
                        s_next.dout_oe = 1'b0;
                        s_next.rx_word = s_reg.rx_sh;
                        s_next.rx_full = 1'b1;
                        s_next.st      = ST_IDLE;
                    end
                end
            end
            ST_SLAVE: begin
                if (!tx_sel) begin
                    s_next.dout_oe = 1'b0;
                    s_next.st      = ST_IDLE;
                end else if (sl_rise && rx_sel && s_reg.nbit != CW'(WORD_BITS)) begin
                    s_next.rx_sh = {s_reg.rx_sh[WORD_BITS-2:0], serial_data_in};
                    s_next.nbit  = CW'(s_reg.nbit + 1'b1);
                    if (s_reg.nbit == CW'(WORD_BITS - 1)) begin
                        s_next.rx_word = {s_reg.rx_sh[WORD_BITS-2:0], serial_data_in};
                        s_next.rx_full = 1'b1;
                    end else if (mode11) begin
                        s_next.dout  = s_reg.tx_sh[WORD_BITS-1];
                        s_next.tx_sh = s_reg.tx_sh << 1;
                    end
                end else if (sl_fall && !mode11 && s_reg.nbit != '0
                             && s_reg.nbit != CW'(WORD_BITS)) begin
                    s_next.dout  = s_reg.tx_sh[WORD_BITS-1];
                    s_next.tx_sh = s_reg.tx_sh << 1;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // Write channel, after transfer logic so a new word re-arms pending
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = addr_ok(s_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case ({s_reg.awaddr[7:2], 2'b00})
                ADDR_CTRL: begin
                    wv           = merge(s_reg.ctrl, s_reg.wdata, s_reg.wstrb);
                    s_next.ctrl  = wv & CTRL_MASK;
                    s_next.fs_o  = (s_reg.st == ST_IDLE) ? wv[CTRL_TXPOL] : s_next.fs_o;
                end
                ADDR_TXDATA: begin
                    wv             = merge(32'(s_reg.tx_word), s_reg.wdata, s_reg.wstrb);
                    s_next.tx_word = wv[WORD_BITS-1:0];
                    s_next.pend    = 1'b1;
                end
                default: ;
            endcase
        end
        s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
        s_next.wready  = ~s_next.w_got & ~s_next.bvalid;
        s_next.arready = ~s_next.rvalid;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg      <= '0;
            s_reg.ctrl <= CTRL_RESET;
            s_reg.st   <= ST_IDLE;
            s_reg.clk_o <= 1'b1;
            s_reg.fs_o <= CTRL_RESET[CTRL_TXPOL];
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready        = s_reg.awready;
    assign s_axi_wready         = s_reg.wready;
    assign s_axi_bresp          = s_reg.bresp;
    assign s_axi_bvalid         = s_reg.bvalid;
    assign s_axi_arready        = s_reg.arready;
    assign s_axi_rdata          = s_reg.rdata;
    assign s_axi_rresp          = s_reg.rresp;
    assign s_axi_rvalid         = s_reg.rvalid;
    assign serial_bit_clock_out = s_reg.clk_o;
    assign serial_bit_clock_oe  = s_reg.ctrl[CTRL_TXCDIR];
    assign tx_frame_sync_out    = s_reg.fs_o;
    assign tx_frame_sync_oe     = s_reg.ctrl[CTRL_TXFDIR];
    assign serial_data_out      = s_reg.dout;
    assign serial_data_out_oe   = s_reg.dout_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_enable_low: assert property (s_reg.st inside {ST_LEAD, ST_LOW, ST_HIGH}
        && s_reg.ctrl[CTRL_TXPOL] |-> !s_reg.fs_o)
        else $error("master slave enable not low during transfer");
    a_lag_enable: assert property (s_reg.st == ST_LAG && s_reg.ctrl[CTRL_TXPOL]
        |-> !s_reg.fs_o && s_reg.clk_o)
        else $error("slave enable or clock wrong during lag");
    a_release_11b: assert property ($rose(s_reg.st == ST_LAG) && mode11
        |-> !s_reg.dout_oe && $past(s_reg.dout_oe))
        else $error("data not released at last rising edge");
    a_launch_fall: assert property (master && !mode11 && $past(s_reg.dout_oe)
        && s_reg.dout_oe && $changed(s_reg.dout) |-> $fell(s_reg.clk_o))
        else $error("data launched off the falling edge");
    a_launch_rise: assert property (master && mode11 && s_reg.st != ST_LEAD
        && $past(s_reg.st) != ST_LEAD && $changed(s_reg.dout) |-> $rose(s_reg.clk_o))
        else $error("data launched off the rising edge");
    a_sample_rise: assert property (master && $changed(s_reg.nbit)
        && s_reg.nbit != '0 |-> $rose(s_reg.clk_o))
        else $error("input sampled off the rising edge");
    a_slave_release: assert property (s_reg.st == ST_SLAVE && !tx_sel
        |=> !s_reg.dout_oe && s_reg.st == ST_IDLE)
        else $error("slave data not released after enable high");
    a_phase_tick: assert property (master && $changed(s_reg.clk_o)
        |-> $past(tick))
        else $error("clock edge off a rate period boundary");
    a_lead_before: assert property ($rose(s_reg.st == ST_LEAD)
        |-> s_reg.clk_o ##1 (s_reg.clk_o throughout (s_reg.st == ST_LEAD)[*1]))
        else $error("clock moved at slave enable fall");

    c_master_10b: cover property (!mode11 && s_reg.st == ST_LAG ##1 s_reg.st == ST_IDLE);
    c_master_11b: cover property (mode11 && s_reg.st == ST_LAG ##1 s_reg.st == ST_IDLE);
    c_slave_word: cover property (s_reg.st == ST_SLAVE && $rose(s_reg.rx_full));
    c_bad_addr:   cover property (s_reg.bvalid && s_reg.bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ===== spi_far_slave.sv
// Far-side SPI slave that returns a fixed word
`timescale 1ns/100ps
`default_nettype none
module spi_far_slave #(parameter logic [7:0] REPLY = 8'h3c) (
    input  wire logic       sck,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    input  wire logic       ph,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh = 8'h00;
    logic       last = 1'b0;
    logic       seen = 1'b0;
    always @(negedge sel_n) begin
        sh = REPLY;
        seen = 1'b0;
    end
    always @(posedge sel_n) last = sh[7];
    always @(posedge sck) if (!sel_n && !ph) got = {got[6:0], mosi};
    always @(negedge sck) begin
        if (!sel_n && ph) got = {got[6:0], mosi};
        if (!sel_n && seen) sh = {sh[6:0], 1'b0};
        if (!sel_n) seen = 1'b1;
    end
    assign miso = sel_n ? ~last : sh[7];
endmodule
`default_nettype wire

// ===== spi_clock_stop_port_test.sv
// Self-checking bench: registers, master transfers and a slave transfer
`timescale 1ns/100ps
`default_nettype none
module spi_clock_stop_port_test;
    import spi_cs_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ph = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        serial_bit_clock_out, serial_bit_clock_oe, tx_frame_sync_out, tx_frame_sync_oe;
    logic        serial_data_out, serial_data_out_oe, serial_data_in, rate_clock_in = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wresp;
    logic        fm_clk = 1'b1, fm_sel = 1'b1;
    int          fails = 0, checked = 0;
    time         t_fs, t_r;
    wire         serial_bit_clock_in = serial_bit_clock_oe ? serial_bit_clock_out : fm_clk;
    wire         tx_frame_sync_in = tx_frame_sync_oe ? tx_frame_sync_out : fm_sel;
    wire         rx_frame_sync_in = tx_frame_sync_in;
    wire         mosi = serial_data_out_oe ? serial_data_out : ~serial_data_out;
    spi_clock_stop_port dut (.*);
    spi_far_slave far (.sck(serial_bit_clock_in), .sel_n(tx_frame_sync_in), .mosi(mosi),
        .ph(ph), .miso(serial_data_in), .got(got));
    always #50 clk = ~clk;
    always @(negedge tx_frame_sync_in) t_fs = $time;
    always @(posedge serial_bit_clock_in) t_r = $time;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_bvalid);
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADDR_CTRL, d, r);
        chk("ctrl", CTRL_RESET, d);
        rd(8'h10, d, r);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h10, 32'h0);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, wresp});
    endtask
    task automatic t_xfer(input logic [1:0] m, input logic [7:0] dv);
        logic [31:0] d;
        logic [1:0]  r;
        int          h, l;
        time         t;
        h = dv[0] ? (dv + 1) / 2 : dv / 2 + 1;
        l = dv[0] ? (dv + 1) / 2 : dv / 2;
        ph <= m[0];
        wr(ADDR_CTRL, {8'h00, dv, 16'h00bc} | {30'h0, m});
        chk("pins out", 32'h3, {30'h0, serial_bit_clock_oe, tx_frame_sync_oe});
        wr(ADDR_TXDATA, 32'h0000_00a5);
        @(negedge serial_bit_clock_in) #1;
        t = $time;
        chk("lead", 4 * (m[0] ? h + l : h), 32'((t - t_fs) / 100));
        @(posedge serial_bit_clock_in) #1;
        chk("low", 4 * l, 32'(($time - t) / 100));
        t = $time;
        @(negedge serial_bit_clock_in) #1;
        chk("high", 4 * h, 32'(($time - t) / 100));
        @(negedge serial_data_out_oe) #1;
        chk("release", m[0] ? 0 : 4 * h, 32'(($time - t_r) / 100));
        @(posedge tx_frame_sync_in) #1;
        chk("lag", 4 * (m[0] ? h : h + l), 32'(($time - t_r) / 100));
        chk("sent", 32'h0000_00a5, {24'h0, got});
        rd(ADDR_RXDATA, d, r);
        chk("received", 32'h0000_003c, d);
        rd(ADDR_STATUS, d, r);
        chk("status", 32'h0, d);
    endtask
    task automatic t_slave();
        logic [31:0] d;
        logic [1:0]  r;
        ph <= 1'b0;
        wr(ADDR_CTRL, 32'h0001_001e);
        wr(ADDR_TXDATA, 32'h0000_005a);
        fm_sel <= 1'b0;
        repeat (4) @(posedge clk);
        repeat (8) begin
            fm_clk <= 1'b0;
            repeat (4) @(posedge clk);
            fm_clk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        fm_sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk("slave release", 32'h0, {31'h0, serial_data_out_oe});
        chk("slave sent", 32'h0000_005a, {24'h0, got});
        rd(ADDR_RXDATA, d, r);
        chk("slave received", 32'h0000_003c, d);
    endtask
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_xfer(2'b10, 8'h01);
        t_xfer(2'b11, 8'h02);
        t_slave();
        summarize();
    end
    initial begin
        #1ms;
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
